// >>> pkg/dbt_map.svh
// register indices, field positions, reset values and timing counts of the dual byte timer
`ifndef DBT_MAP_SVH
`define DBT_MAP_SVH

// printed offsets are register indices; byte address is index times four
`define DBT_IDX_CTRL 18'h0fe18
`define DBT_IDX_PRESEL 18'h0fe19
`define DBT_IDX_LOW_CNT 18'h0fe1a
`define DBT_IDX_HIGH_CNT 18'h0fe1b
`define DBT_IDX_LOW_MATCH 18'h0fe1c
`define DBT_IDX_HIGH_MATCH 18'h0fe1d

// timer_control fields
`define DBT_CTRL_HIGH_RUN 7
`define DBT_CTRL_LOW_RUN 6
`define DBT_CTRL_CASCADE 5
`define DBT_CTRL_PWM 4
`define DBT_CTRL_HIGH_FLAG 3
`define DBT_CTRL_HIGH_IE 2
`define DBT_CTRL_LOW_FLAG 1
`define DBT_CTRL_LOW_IE 0

// prescaler_select fields
`define DBT_PRE_HIGH_MSB 7
`define DBT_PRE_HIGH_LSB 4
`define DBT_PRE_LOW_MSB 3
`define DBT_PRE_LOW_LSB 0

// reset values and the all-ones compare value
`define DBT_RST_BYTE 8'h00
`define DBT_RST_WORD 32'h0000_0000
`define DBT_ALL_ONES 8'hff

// slow count clock is every second core clock
`define DBT_SLOW_TICK_CYCLES 2

`endif

// >>> pkg/dbt_pkg.sv
// types shared by the dual byte timer
package dbt_pkg;

  typedef enum logic [3:0] {
    DBT_MODE_TOGGLE = 4'b0001,
    DBT_MODE_PWM8 = 4'b0010,
    DBT_MODE_CASCADE = 4'b0100,
    DBT_MODE_CASC_PWM = 4'b1000
  } dbt_mode_type;

  typedef struct packed {
    logic enable;
    logic [2:0] code;
  } dbt_prescale_type;

endpackage : dbt_pkg

// >>> verif/dbt_event_source.sv
// external event source driving the timer count input
`timescale 1ns/100ps
`default_nettype none
module dbt_event_source (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [3:0] half_len,
  output logic ext_event_in
);
  logic [3:0] cnt_reg;
  // each level lasts several cycles so a two-flop synchroniser sees it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      ext_event_in <= 1'b0;
    end else if (!enable) begin
      cnt_reg <= 4'h0;
      ext_event_in <= 1'b0;
    end else if (cnt_reg + 4'h1 >= half_len) begin
      cnt_reg <= 4'h0;
      ext_event_in <= !ext_event_in;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : dbt_event_source
`default_nettype wire

// >>> verif/dbt_timer_monitor.sv
// port assertions for the dual byte timer
`timescale 1ns/100ps
`default_nettype none
`include "dbt_map.svh"
module dbt_timer_monitor import dbt_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_event_in,
  input wire logic ext_count_sel,
  input wire logic low_wave_out,
  input wire logic high_wave_out,
  input wire logic irq_req
);
  logic [7:0] ctrl_reg;
  // shadow of software control; flag bits are not tracked, only run and enable bits are used
  wire logic ctrl_wr = psel && penable && pready && pwrite && !pslverr && paddr == {`DBT_IDX_CTRL, 2'b00};
  wire logic ie_any = ctrl_reg[0] | ctrl_reg[2];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 8'h00;
    end else if (ctrl_wr) begin
      ctrl_reg <= pwdata[7:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  a_ready_once: assert property (s_setup |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read bus not quiet");
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_reset_idle: assert property ($rose(rst_n) |-> low_wave_out && high_wave_out && !irq_req)
    else $error("outputs wrong after reset");
  a_low_stop_high: assert property (!ctrl_reg[6] [*3] |-> low_wave_out)
    else $error("low output not high while stopped");
  a_high_stop_high: assert property (!ctrl_reg[7] [*3] |-> high_wave_out)
    else $error("high output not high while stopped");
  a_irq_cause: assert property (irq_req |-> ie_any || $past(ie_any))
    else $error("request without enable");
endmodule : dbt_timer_monitor
`default_nettype wire

// >>> verif/test_dbt_timer.sv
// self-checking testbench for the dual byte timer
`timescale 1ns/100ps
`default_nettype none
`include "dbt_map.svh"
module test_dbt_timer import dbt_pkg::*; ;
  logic core_clk, rst_n, psel, penable, pwrite, ext_count_sel, ev_en, er;
  logic pready, pslverr, low_wave_out, high_wave_out, irq_req, ext_event_in;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] mdl [6];
  int miscompares, samples_checked, cyc, seed, m, t0, t1, t2;
  dbt_prescale_type pre;
  // expected periods queued by the model, popped at each measured result
  int exp_q[$];
  dbt_timer u_dbt_timer (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_event_in(ext_event_in), .ext_count_sel(ext_count_sel),
    .low_wave_out(low_wave_out), .high_wave_out(high_wave_out), .irq_req(irq_req));
  dbt_event_source u_dbt_event_source (.core_clk(core_clk), .rst_n(rst_n), .enable(ev_en),
    .half_len(4'h3), .ext_event_in(ext_event_in));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      end_sim();
    end
  end
  function automatic int pcount(dbt_prescale_type p);
    return p.enable ? 2 << p.code : 1;
  endfunction : pcount
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk
  task apb(input logic w, input int i, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {`DBT_IDX_CTRL + 18'(i), 2'b00};
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // counters are read-only, so the model keeps them at zero while stopped
    if (w && i != 2 && i != 3 && i < 6) mdl[i] = d;
  endtask : apb
  task setup(input logic [7:0] ctl, input logic [7:0] ps, input logic [7:0] lm, input logic [7:0] hm);
    apb(1'b1, 0, 8'h00);
    apb(1'b1, 1, ps);
    apb(1'b1, 4, lm);
    apb(1'b1, 5, hm);
    apb(1'b1, 0, ctl);
  endtask : setup
  task wt(input int h, input logic v);
    while ((h ? high_wave_out : low_wave_out) !== v) @(posedge core_clk);
  endtask : wt
  // time up to the first falling edge after start is skipped: slow clock phase is not aligned to run
  task meas(input int h, input int elo, input int eper);
    wt(h, 1'b1);
    wt(h, 1'b0);
    t0 = cyc;
    wt(h, 1'b1);
    t1 = cyc;
    wt(h, 1'b0);
    t2 = cyc;
    exp_q.push_back(eper);
    if (elo > 0) chk("low phase", elo, t1 - t0);
    chk("period", exp_q.pop_front(), t2 - t0);
  endtask : meas
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 20'h0;
    pwdata = 32'h0;
    ext_count_sel = 1'b0;
    ev_en = 1'b0;
    seed = 69350;
    cyc = 0;
    mdl = '{default: 8'h00};
    rst_n = 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, i, 8'h00);
      chk("reset value", 32'h0, rd);
    end
    for (int i = 1; i < 7; i++) begin
      apb(1'b1, i, 8'($random(seed)));
      apb(1'b0, i, 8'h00);
      chk("readback", (i < 6) ? {24'h0, mdl[i]} : 32'h0, rd);
      chk("slave error", i == 6, er);
    end
    for (int c = 0; c < 9; c++) begin
      pre = (c == 0) ? 4'h0 : {1'b1, 3'(c - 1)};
      m = $random(seed) & 1;
      setup(8'hc0, {pre, pre}, 8'(m), 8'(m));
      meas(0, 0, 4 * (m + 1) * pcount(pre));
      meas(1, 0, 4 * (m + 1) * pcount(pre));
    end
    for (int c = 0; c < 2; c++) begin
      pre = {c[0], 3'h0};
      m = $random(seed) & 127;
      setup(8'hd0, {pre, pre}, 8'(m), 8'(m));
      meas(0, (m + 1) * pcount(pre), 256 * pcount(pre));
      meas(1, (m + 1) * pcount(pre), 256 * pcount(pre));
      // new match while running only takes effect from the next wrap
      apb(1'b1, 4, 8'(m ^ 64));
      meas(0, ((m ^ 64) + 1) * pcount(pre), 256 * pcount(pre));
    end
    setup(8'he0, 8'h00, 8'h01, 8'h02);
    meas(0, 0, 8);
    meas(1, 0, 2 * 3 * 4);
    setup(8'hf0, 8'h00, 8'h80, 8'h01);
    meas(0, 129, 256);
    meas(1, 0, 2 * 2 * 256);
    setup(8'hc0, 8'h00, 8'hff, 8'hff);
    repeat (20) @(posedge core_clk);
    chk("fixed low", 2'b00, {high_wave_out, low_wave_out});
    ext_count_sel <= 1'b1;
    ev_en <= 1'b1;
    setup(8'h40, 8'h00, 8'h02, 8'h00);
    meas(0, 0, 2 * 3 * 6);
    ev_en <= 1'b0;
    ext_count_sel <= 1'b0;
    for (int h = 0; h < 2; h++) begin
      setup(h ? 8'h84 : 8'h41, 8'h00, 8'h01, 8'h01);
      repeat (20) @(posedge core_clk);
      apb(1'b0, 0, 8'h00);
      chk("match flag", 1, rd[h ? 3 : 1]);
      chk("irq raised", 1, irq_req);
      apb(1'b1, 0, h ? 8'h80 : 8'h40);
      repeat (2) @(posedge core_clk);
      chk("irq masked", 0, irq_req);
    end
    end_sim();
  end
  task end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
endmodule : test_dbt_timer
bind dbt_timer dbt_timer_monitor u_dbt_timer_monitor (.core_clk(core_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_event_in(ext_event_in), .ext_count_sel(ext_count_sel),
  .low_wave_out(low_wave_out), .high_wave_out(high_wave_out), .irq_req(irq_req));
`default_nettype wire

// >>> verilog/dbt_timer.sv
// dual byte timer with prescalers, match buffers, toggle and pwm outputs, apb slave
`timescale 1ns/100ps
`default_nettype none
`include "dbt_map.svh"

module dbt_timer
  import dbt_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_event_in,
  input wire logic ext_count_sel,
  output logic low_wave_out,
  output logic high_wave_out,
  output logic irq_req
);

  // last prescaler state before a tick: divide by 1, or 2 to 256
  function automatic logic [7:0] prescale_last(input dbt_prescale_type cfg);
    logic [8:0] ratio;
    ratio = 9'h000;
    if (cfg.enable) begin
      ratio = 9'h002 << cfg.code;
    end else begin
      ratio = 9'h001;
    end
    return 8'(ratio - 9'h001);
  endfunction : prescale_last

  function automatic logic addr_hit(input logic [19:0] addr, input logic [17:0] idx);
    return (addr[19:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : addr_hit

  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] presel_reg;
  logic [7:0] low_match_reg;
  logic [7:0] high_match_reg;
  logic [7:0] low_cnt_reg;
  logic [7:0] low_cnt_next;
  logic [7:0] high_cnt_reg;
  logic [7:0] high_cnt_next;
  logic [7:0] low_buf_reg;
  logic [7:0] high_buf_reg;
  dbt_prescale_type low_cfg_reg;
  dbt_prescale_type high_cfg_reg;
  logic [7:0] low_pre_reg;
  logic [7:0] high_pre_reg;
  logic slow_tick_reg;
  logic sync_first_reg;
  logic sync_second_reg;
  logic sync_third_reg;
  logic low_out_reg;
  logic high_out_reg;
  logic irq_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  dbt_mode_type mode;

  // bus decode
  wire setup_phase = psel & ~penable;
  wire access_done = psel & penable & pready_reg;
  wire wr_take = access_done & pwrite;
  wire hit_ctrl = addr_hit(paddr, `DBT_IDX_CTRL);
  wire hit_presel = addr_hit(paddr, `DBT_IDX_PRESEL);
  wire hit_low_cnt = addr_hit(paddr, `DBT_IDX_LOW_CNT);
  wire hit_high_cnt = addr_hit(paddr, `DBT_IDX_HIGH_CNT);
  wire hit_low_match = addr_hit(paddr, `DBT_IDX_LOW_MATCH);
  wire hit_high_match = addr_hit(paddr, `DBT_IDX_HIGH_MATCH);
  wire addr_miss = ~(hit_ctrl | hit_presel | hit_low_cnt | hit_high_cnt | hit_low_match | hit_high_match);
  wire wr_ctrl = wr_take & hit_ctrl;
  wire wr_presel = wr_take & hit_presel;
  wire wr_low_match = wr_take & hit_low_match;
  wire wr_high_match = wr_take & hit_high_match;
  // counter addresses accept writes silently: they are read-only
  wire [7:0] rd_byte = hit_ctrl ? ctrl_reg :
                       hit_presel ? presel_reg :
                       hit_low_cnt ? low_cnt_reg :
                       hit_high_cnt ? high_cnt_reg :
                       hit_low_match ? low_match_reg :
                       hit_high_match ? high_match_reg : `DBT_RST_BYTE;

  // control fields
  wire low_run = ctrl_reg[`DBT_CTRL_LOW_RUN];
  wire high_run = ctrl_reg[`DBT_CTRL_HIGH_RUN];
  wire cascade_select = ctrl_reg[`DBT_CTRL_CASCADE];
  wire pwm_select = ctrl_reg[`DBT_CTRL_PWM];
  wire [3:0] low_cfg_in = presel_reg[`DBT_PRE_LOW_MSB:`DBT_PRE_LOW_LSB];
  wire [3:0] high_cfg_in = presel_reg[`DBT_PRE_HIGH_MSB:`DBT_PRE_HIGH_LSB];

  always_comb begin
    case ({cascade_select, pwm_select})
      2'b00: mode = DBT_MODE_TOGGLE;
      2'b01: mode = DBT_MODE_PWM8;
      2'b10: mode = DBT_MODE_CASCADE;
      2'b11: mode = DBT_MODE_CASC_PWM;
      default: mode = DBT_MODE_TOGGLE;
    endcase
  end

  wire mode_toggle = (mode == DBT_MODE_TOGGLE);
  wire mode_pwm8 = (mode == DBT_MODE_PWM8);
  wire mode_cascade = (mode == DBT_MODE_CASCADE);
  wire mode_casc_pwm = (mode == DBT_MODE_CASC_PWM);

  // event input: only the second stage reads the first
  wire ext_pulse = sync_second_reg & ~sync_third_reg;

  // low half count source
  // pwm select with event input misbehaves by design; software avoids it
  wire low_src = pwm_select ? 1'b1 :
                 ext_count_sel ? ext_pulse : slow_tick_reg;

  wire [7:0] low_pre_last = prescale_last(low_cfg_reg);
  wire low_pre_end = (low_pre_reg == low_pre_last);
  wire low_tick = low_run & low_src & low_pre_end;
  wire low_at_match = (low_cnt_reg == low_buf_reg);
  wire low_match_ev = low_tick & low_at_match;
  wire low_ovf_ev = low_tick & (low_cnt_reg == `DBT_ALL_ONES);
  wire low_clr_on_match = mode_toggle | mode_cascade;
  wire low_reset_ev = low_match_ev & low_clr_on_match;
  wire low_wrap = low_tick & (low_cnt_next == `DBT_RST_BYTE);

  // high half count source
  logic high_src;
  always_comb begin
    case (mode)
      DBT_MODE_TOGGLE: high_src = slow_tick_reg;
      DBT_MODE_PWM8: high_src = 1'b1;
      DBT_MODE_CASCADE: high_src = low_match_ev;
      DBT_MODE_CASC_PWM: high_src = low_ovf_ev;
      default: high_src = 1'b0;
    endcase
  end

  wire [7:0] high_pre_last = prescale_last(high_cfg_reg);
  wire high_pre_end = (high_pre_reg == high_pre_last);
  wire high_tick = high_run & high_src & high_pre_end;
  wire high_at_match = (high_cnt_reg == high_buf_reg);
  wire high_match_ev = high_tick & high_at_match;
  wire high_ovf_ev = high_tick & (high_cnt_reg == `DBT_ALL_ONES);
  wire high_clr_on_match = ~mode_pwm8;
  wire high_reset_ev = high_match_ev & high_clr_on_match;
  wire high_wrap = high_tick & (high_cnt_next == `DBT_RST_BYTE);
  wire high_is_pwm = mode_pwm8;

  // counters
  always_comb begin
    if (!low_run) begin
      low_cnt_next = `DBT_RST_BYTE;
    end else if (low_reset_ev) begin
      low_cnt_next = `DBT_RST_BYTE;
    end else if (low_tick) begin
      low_cnt_next = low_cnt_reg + 8'h01;
    end else begin
      low_cnt_next = low_cnt_reg;
    end
  end

  always_comb begin
    if (!high_run) begin
      high_cnt_next = `DBT_RST_BYTE;
    end else if (high_reset_ev) begin
      high_cnt_next = `DBT_RST_BYTE;
    end else if (high_tick) begin
      high_cnt_next = high_cnt_reg + 8'h01;
    end else begin
      high_cnt_next = high_cnt_reg;
    end
  end

  // control with flags: hardware set wins over a software clear
  always_comb begin
    ctrl_next = wr_ctrl ? pwdata[7:0] : ctrl_reg;
    if (low_wrap) begin
      ctrl_next[`DBT_CTRL_LOW_FLAG] = 1'b1;
    end
    if (high_wrap) begin
      ctrl_next[`DBT_CTRL_HIGH_FLAG] = 1'b1;
    end
  end

  wire irq_next = (ctrl_next[`DBT_CTRL_LOW_FLAG] & ctrl_next[`DBT_CTRL_LOW_IE]) |
                  (ctrl_next[`DBT_CTRL_HIGH_FLAG] & ctrl_next[`DBT_CTRL_HIGH_IE]);

  // outputs: stopped high, all-ones match low, else toggle or pwm
  logic low_out_next;
  always_comb begin
    if (!low_run) begin
      low_out_next = 1'b1;
    end else if (low_match_reg == `DBT_ALL_ONES) begin
      low_out_next = 1'b0;
    end else if (pwm_select) begin
      if (low_match_ev) begin
        low_out_next = 1'b1;
      end else if (low_ovf_ev) begin
        low_out_next = 1'b0;
      end else begin
        low_out_next = low_out_reg;
      end
    end else begin
      low_out_next = low_out_reg ^ low_match_ev;
    end
  end

  logic high_out_next;
  always_comb begin
    if (!high_run) begin
      high_out_next = 1'b1;
    end else if (high_match_reg == `DBT_ALL_ONES) begin
      high_out_next = 1'b0;
    end else if (high_is_pwm) begin
      if (high_match_ev) begin
        high_out_next = 1'b1;
      end else if (high_ovf_ev) begin
        high_out_next = 1'b0;
      end else begin
        high_out_next = high_out_reg;
      end
    end else begin
      high_out_next = high_out_reg ^ high_match_ev;
    end
  end

  // bus registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `DBT_RST_BYTE;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      presel_reg <= `DBT_RST_BYTE;
    end else if (wr_presel) begin
      presel_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_match_reg <= `DBT_RST_BYTE;
      high_match_reg <= `DBT_RST_BYTE;
    end else begin
      if (wr_low_match) begin
        low_match_reg <= pwdata[7:0];
      end
      if (wr_high_match) begin
        high_match_reg <= pwdata[7:0];
      end
    end
  end

  // zero wait state: answer in the cycle after setup
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= `DBT_RST_WORD;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase & addr_miss;
      prdata_reg <= (setup_phase & ~pwrite) ? {24'h000000, rd_byte} : `DBT_RST_WORD;
    end
  end

  // slow tick and event synchroniser
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_tick_reg <= 1'b0;
      sync_first_reg <= 1'b0;
      sync_second_reg <= 1'b0;
      sync_third_reg <= 1'b0;
    end else begin
      slow_tick_reg <= ~slow_tick_reg;
      sync_first_reg <= ext_event_in;
      sync_second_reg <= sync_first_reg;
      sync_third_reg <= sync_second_reg;
    end
  end

  // prescalers: a counter reset coincides with the tick that wraps them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_pre_reg <= `DBT_RST_BYTE;
    end else if (!low_run || low_reset_ev) begin
      low_pre_reg <= `DBT_RST_BYTE;
    end else if (low_src) begin
      low_pre_reg <= low_pre_end ? `DBT_RST_BYTE : low_pre_reg + 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_pre_reg <= `DBT_RST_BYTE;
    end else if (!high_run || high_reset_ev) begin
      high_pre_reg <= `DBT_RST_BYTE;
    end else if (high_src) begin
      high_pre_reg <= high_pre_end ? `DBT_RST_BYTE : high_pre_reg + 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg <= `DBT_RST_BYTE;
      high_cnt_reg <= `DBT_RST_BYTE;
    end else begin
      low_cnt_reg <= low_cnt_next;
      high_cnt_reg <= high_cnt_next;
    end
  end

  // match buffers and prescaler settings follow the registers while stopped and otherwise change only at a period boundary
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_buf_reg <= `DBT_RST_BYTE;
      low_cfg_reg <= 4'h0;
    end else if (!low_run || low_wrap) begin
      low_buf_reg <= low_match_reg;
      low_cfg_reg <= low_cfg_in;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_buf_reg <= `DBT_RST_BYTE;
      high_cfg_reg <= 4'h0;
    end else if (!high_run || high_wrap) begin
      high_buf_reg <= high_match_reg;
      high_cfg_reg <= high_cfg_in;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_out_reg <= 1'b1;
      high_out_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else begin
      low_out_reg <= low_out_next;
      high_out_reg <= high_out_next;
      irq_reg <= irq_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign low_wave_out = low_out_reg;
  assign high_wave_out = high_out_reg;
  assign irq_req = irq_reg;

endmodule : dbt_timer

`default_nettype wire
